// File: ccp_pkg.sv
// Purpose: Constants for the configuration control pin logic
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes:   Register map, field positions, modes and timing counts
// Contract
// - Reset input during configuration abandons the load and restarts it.
// - After configuration reset input sets cells asynchronously or is a plain input.
// - Master and async peripheral modes drive config clock to strobe data.
// - Slave mode and readback use an external config clock with data.
// - Daisy-chain lead in master, peripheral or system-bus mode drives clock.
// - Start-up holds off while the done pin is sensed low.
// - Done pin is open-drain, released high only after configuration completes.
// - Low program_restart_n restarts configuration and resets boundary scan.
// - During configuration, low readback trigger asserts tristate_all.
// - After configuration an option decides if the trigger still drives tristate_all.
// - With readback enabled, trigger falling edge starts readback at frame zero.
// - Readback data leaves on the shared pin; boundary scan puts TDO there.
// - Error output goes low on RAM or core init failure in listed modes.
// - The error pin also carries the host port interrupt, active low.
// - Done release and other pin release use separate delay options.
// - Mode select inputs are captured on the rising edge of init status.
// - config_busy_high stays high and config_busy_low_n low until complete.
package ccp_pkg;
  localparam logic [7:0] CCP_REG_CTRL  = 8'h00;
  localparam logic [7:0] CCP_REG_LEN   = 8'h04;
  localparam logic [7:0] CCP_REG_DLY   = 8'h08;
  localparam logic [7:0] CCP_REG_STAT  = 8'h0C;
  localparam logic [7:0] CCP_REG_IRQS  = 8'h10;
  localparam logic [7:0] CCP_REG_IRQM  = 8'h14;
  localparam logic [7:0] CCP_REG_DATA  = 8'h18;
  localparam int CCP_CTRL_RB_EN  = 0;
  localparam int CCP_CTRL_TS_AFT = 1;
  localparam int CCP_CTRL_GSR_EN = 2;
  localparam int CCP_CTRL_LEAD   = 3;
  localparam int CCP_IRQ_DONE    = 0;
  localparam int CCP_IRQ_RESTART = 1;
  localparam int CCP_IRQ_RBDONE  = 2;
  localparam int CCP_IRQ_ERR     = 3;
  localparam logic [3:0]  CCP_CTRL_RST = 4'h0;
  localparam logic [15:0] CCP_LEN_RST  = 16'h0010;
  localparam logic [15:0] CCP_DLY_RST  = 16'h0404;
  localparam logic [3:0] CCP_MODE_MASTER = 4'h0;
  localparam logic [3:0] CCP_MODE_APER   = 4'h1;
  localparam logic [3:0] CCP_MODE_SSER   = 4'h2;
  localparam logic [3:0] CCP_MODE_SPAR   = 4'h3;
  localparam logic [3:0] CCP_MODE_SYSBUS = 4'h4;
  localparam logic [3:0] CCP_MODE_JTAG   = 4'h5;
  localparam int CCP_CLK_NS       = 50;
  localparam int CCP_CONFIG_CLOCK_HALF_NS = 250;
  localparam logic [3:0] CCP_CONFIG_CLOCK_HALF =
    4'((CCP_CONFIG_CLOCK_HALF_NS + CCP_CLK_NS - 1) / CCP_CLK_NS);
  localparam logic [7:0] CCP_RB_FRAMES = 8'h04;
  typedef enum logic [1:0] {
    CCP_WAIT_INIT = 2'b00,
    CCP_LOAD      = 2'b01,
    CCP_STARTUP   = 2'b11,
    CCP_USER      = 2'b10
  } ccp_state_t;
endpackage

// File: ccp_top.sv
// Purpose: Configuration control pins: restart, clocking, done, readback, error
// Assumes: Pins from outside pass two flops; init_fail, cell_state, tdo same clock
// Notes:   Open-drain and driven pins use active-low output enables
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ccp_top
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Configuration pins
  input  wire logic        cfg_reset_pin,
  input  wire logic        program_restart_n,
  input  wire logic        init_pin,
  input  wire logic [3:0]  mode_sel,
  input  wire logic        config_clock_i,
  output logic             config_clock_o,
  output logic             config_clock_oe_n,
  input  wire logic        cfg_din,
  input  wire logic [7:0]  cfg_d,
  input  wire logic        done_i,
  output logic             done_o,
  output logic             done_oe_n,
  input  wire logic        readback_cfg_n,
  output logic             readback_tdo_o,
  output logic             host_port_irq_n,
  output logic             config_busy_high,
  output logic             config_busy_low_n,
  output logic             tristate_all,
  // Core side
  input  wire logic        init_fail,
  input  wire logic [7:0]  cell_state,
  input  wire logic        bscan_active,
  input  wire logic        bscan_tdo,
  output logic             bscan_reset,
  output logic             cell_gsr,
  output logic             user_reset,
  output logic             user_io_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int PW = 19;
  logic [PW-1:0] pin_s1_q, pin_s2_q;
  logic          config_clock_s3_q, rbt_s3_q, init_s3_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Restart and trigger pins rest high, so sync them from their idle level
      pin_s1_q <= 19'h20001;
      pin_s2_q <= 19'h20001;
      config_clock_s3_q <= 1'b0;
      rbt_s3_q <= 1'b1;
      init_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= {cfg_reset_pin, program_restart_n, init_pin, mode_sel, config_clock_i,
                   cfg_din, cfg_d, done_i, readback_cfg_n};
      pin_s2_q <= pin_s1_q;
      config_clock_s3_q <= pin_s2_q[11];
      rbt_s3_q <= pin_s2_q[0];
      init_s3_q <= pin_s2_q[16];
    end
  end
  logic       rst_s, prg_n_s, init_s, config_clock_s, din_s, done_s, rbt_s;
  logic [3:0] mode_s;
  logic [7:0] d_s;
  assign {rst_s, prg_n_s, init_s, mode_s, config_clock_s, din_s, d_s, done_s, rbt_s} = pin_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0]  ctrl_q, irq_s_q, irq_m_q, irq_ev;
  logic [15:0] len_q, dly_q, cnt_q;
  logic [7:0]  byte_q;
  logic [3:0]  mode_q;
  ccp_state_t  st_q;
  logic        aw_hit_q, w_hit_q, rb_act_q, done_rel_q;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        wr_go;
  assign wr_go = aw_hit_q && w_hit_q && !s_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_hit_q <= 1'b0;
      w_hit_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q <= s_awaddr;
        aw_hit_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_q <= s_wdata;
        ws_q <= s_wstrb;
        w_hit_q <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        s_bvalid <= 1'b1;
        if (aw_q == CCP_REG_CTRL || aw_q == CCP_REG_LEN || aw_q == CCP_REG_DLY ||
            aw_q == CCP_REG_IRQS || aw_q == CCP_REG_IRQM)
          s_bresp <= 2'b00;
        else
          s_bresp <= 2'b10;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        aw_hit_q <= 1'b0;
        w_hit_q <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Write strobe lane 0 gates CTRL, IRQS and IRQM writes; LEN and DLY ignore the strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CCP_CTRL_RST;
      len_q <= CCP_LEN_RST;
      dly_q <= CCP_DLY_RST;
      irq_m_q <= 4'h0;
    end else if (wr_go) begin
      if (aw_q == CCP_REG_CTRL && ws_q[0])
        ctrl_q <= w_q[3:0];
      else if (aw_q == CCP_REG_LEN)
        len_q <= w_q[15:0];
      else if (aw_q == CCP_REG_DLY)
        dly_q <= w_q[15:0];
      else if (aw_q == CCP_REG_IRQM && ws_q[0])
        irq_m_q <= w_q[3:0];
    end
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_s_q <= 4'h0;
    else if (wr_go && aw_q == CCP_REG_IRQS && ws_q[0])
      irq_s_q <= (irq_s_q & ~w_q[3:0]) | irq_ev;
    else
      irq_s_q <= irq_s_q | irq_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= 2'b00;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= 2'b00;
      if (s_araddr == CCP_REG_CTRL)
        s_rdata <= {28'h0, ctrl_q};
      else if (s_araddr == CCP_REG_LEN)
        s_rdata <= {16'h0, len_q};
      else if (s_araddr == CCP_REG_DLY)
        s_rdata <= {16'h0, dly_q};
      else if (s_araddr == CCP_REG_STAT)
        s_rdata <= {16'h0, cnt_q[7:0], mode_q, rb_act_q, done_rel_q, st_q};
      else if (s_araddr == CCP_REG_IRQS)
        s_rdata <= {28'h0, irq_s_q};
      else if (s_araddr == CCP_REG_IRQM)
        s_rdata <= {28'h0, irq_m_q};
      else if (s_araddr == CCP_REG_DATA)
        s_rdata <= {24'h0, byte_q};
      else begin
        s_rdata <= 32'h0;
        s_rresp <= 2'b10;
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart and mode capture
  logic restart, init_rise, drive_clk, serial;
  assign restart = !prg_n_s || (rst_s && st_q != CCP_USER);
  assign init_rise = init_s && !init_s3_q;
  assign drive_clk = mode_q == CCP_MODE_MASTER || mode_q == CCP_MODE_APER ||
                     (ctrl_q[CCP_CTRL_LEAD] && mode_q == CCP_MODE_SYSBUS);
  assign serial = mode_q == CCP_MODE_MASTER || mode_q == CCP_MODE_SSER ||
                  mode_q == CCP_MODE_JTAG;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      mode_q <= CCP_MODE_SSER;
    else if (st_q == CCP_WAIT_INIT && init_rise)
      mode_q <= mode_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration clock: driven by divider or sampled from the pin
  logic [3:0] div_q;
  logic       config_clock_q, cedge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
      config_clock_q <= 1'b0;
    end else if (st_q == CCP_LOAD && drive_clk) begin
      if (div_q == CCP_CONFIG_CLOCK_HALF - 4'h1) begin
        div_q <= 4'h0;
        config_clock_q <= !config_clock_q;
      end else
        div_q <= div_q + 4'h1;
    end else begin
      div_q <= 4'h0;
      config_clock_q <= 1'b0;
    end
  end
  // Driven clock: sample at our own rising edge; received: synced edge
  assign cedge = drive_clk && st_q == CCP_LOAD ?
                 (!config_clock_q && div_q == CCP_CONFIG_CLOCK_HALF - 4'h1) :
                 (config_clock_s && !config_clock_s3_q);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_clock_o <= 1'b0;
      config_clock_oe_n <= 1'b1;
    end else begin
      config_clock_o <= config_clock_q;
      config_clock_oe_n <= !(drive_clk && st_q == CCP_LOAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load and start-up sequence
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      st_q <= CCP_WAIT_INIT;
      cnt_q <= 16'h0;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      byte_q <= 8'h00;
      done_rel_q <= 1'b0;
    end else begin
      case (st_q)
        CCP_WAIT_INIT: begin
          if (init_rise) begin
            st_q <= CCP_LOAD;
            cnt_q <= 16'h0;
          end
        end
        CCP_LOAD: begin
          if (cedge) begin
            if (serial) begin
              sh_q <= {sh_q[6:0], din_s};
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                byte_q <= {sh_q[6:0], din_s};
                cnt_q <= cnt_q + 16'h1;
              end
            end else begin
              byte_q <= d_s;
              cnt_q <= cnt_q + 16'h1;
            end
          end
          if (cnt_q == len_q) begin
            st_q <= CCP_STARTUP;
            cnt_q <= 16'h0;
          end
        end
        CCP_STARTUP: begin
          if (!done_rel_q) begin
            if (cnt_q[7:0] >= dly_q[7:0]) begin
              done_rel_q <= 1'b1;
              cnt_q <= 16'h0;
            end else
              cnt_q <= cnt_q + 16'h1;
          end else if (done_s) begin
            if (cnt_q[7:0] >= dly_q[15:8])
              st_q <= CCP_USER;
            else
              cnt_q <= cnt_q + 16'h1;
          end
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback
  logic [7:0]  frame_q;
  logic [15:0] rsh_q;
  logic [3:0]  rbit_q;
  logic        rb_start, rb_end;
  assign rb_start = st_q == CCP_USER && ctrl_q[CCP_CTRL_RB_EN] && !rb_act_q &&
                    !rbt_s && rbt_s3_q;
  assign rb_end = rb_act_q && cedge && rbit_q == 4'hF && frame_q == CCP_RB_FRAMES - 8'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      rb_act_q <= 1'b0;
      frame_q <= 8'h00;
      rbit_q <= 4'h0;
      rsh_q <= 16'h0;
    end else if (rb_start) begin
      rb_act_q <= 1'b1;
      frame_q <= 8'h00;
      rbit_q <= 4'h0;
      rsh_q <= {8'h00, cell_state};
    end else if (rb_act_q && cedge) begin
      rbit_q <= rbit_q + 4'h1;
      rsh_q <= {rsh_q[14:0], 1'b0};
      if (rbit_q == 4'hF) begin
        frame_q <= frame_q + 8'h1;
        rsh_q <= {frame_q + 8'h1, cell_state};
        if (rb_end)
          rb_act_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  logic err;
  assign err = st_q == CCP_LOAD && init_fail && mode_q != CCP_MODE_SYSBUS;
  assign irq_ev = {err, rb_end, restart && st_q != CCP_WAIT_INIT,
                   st_q == CCP_STARTUP && done_rel_q && done_s && cnt_q[7:0] >= dly_q[15:8]};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_o <= 1'b0;
      done_oe_n <= 1'b0;
      config_busy_high <= 1'b1;
      config_busy_low_n <= 1'b0;
      user_io_en <= 1'b0;
      tristate_all <= 1'b0;
      readback_tdo_o <= 1'b0;
      host_port_irq_n <= 1'b1;
      bscan_reset <= 1'b0;
      cell_gsr <= 1'b0;
      user_reset <= 1'b0;
    end else begin
      done_o <= 1'b0;
      done_oe_n <= done_rel_q && !restart;
      config_busy_high <= st_q != CCP_USER || restart;
      config_busy_low_n <= st_q == CCP_USER && !restart;
      user_io_en <= st_q == CCP_USER && !restart;
      if (st_q != CCP_USER)
        tristate_all <= !rbt_s;
      else
        tristate_all <= ctrl_q[CCP_CTRL_TS_AFT] && !rbt_s;
      readback_tdo_o <= bscan_active ? bscan_tdo : (rb_act_q && rsh_q[15]);
      host_port_irq_n <= !(err || |(irq_s_q & irq_m_q));
      bscan_reset <= !prg_n_s;
      cell_gsr <= st_q == CCP_USER && ctrl_q[CCP_CTRL_GSR_EN] && rst_s;
      user_reset <= st_q == CCP_USER && !ctrl_q[CCP_CTRL_GSR_EN] && rst_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_restart;
    !prg_n_s;
  endsequence
  sequence s_incomplete;
    config_busy_high && !config_busy_low_n && done_oe_n == 1'b0;
  endsequence

  chk_restart_state: assert property (@(posedge aclk) disable iff (!aresetn)
    s_restart |=> st_q == CCP_WAIT_INIT)
    else $error("program restart did not return to wait");
  chk_restart_outs: assert property (@(posedge aclk) disable iff (!aresetn)
    s_restart ##1 !restart |=> s_incomplete)
    else $error("restart left done or busy complete");
  chk_reset_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_s && st_q == CCP_LOAD |=> st_q == CCP_WAIT_INIT)
    else $error("reset during load ignored");
  chk_busy_pair: assert property (@(posedge aclk) disable iff (!aresetn)
    config_busy_high == !config_busy_low_n)
    else $error("busy outputs not complementary");
  chk_done_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == CCP_STARTUP && done_rel_q && !done_s && !restart |=> st_q == CCP_STARTUP)
    else $error("start-up ran while done low");
  chk_done_late: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == CCP_LOAD |=> done_oe_n == 1'b0)
    else $error("done released during load");
  chk_mode_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == CCP_WAIT_INIT && init_rise && !restart |=> mode_q == $past(mode_s))
    else $error("mode not captured at init rise");
  chk_ts_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == CCP_LOAD && !rbt_s |=> tristate_all)
    else $error("tristate_all missing in configuration");
  chk_rb_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    rb_start && !restart |=> rb_act_q && frame_q == 8'h00)
    else $error("readback did not start at frame zero");
  chk_err_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    err |=> !host_port_irq_n)
    else $error("init failure not flagged");
  chk_clk_drv: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q == CCP_LOAD && mode_q == CCP_MODE_MASTER && !restart ##1 st_q == CCP_LOAD
    |-> !config_clock_oe_n)
    else $error("config clock not driven in master mode");

endmodule

// File: ccp_host_model.sv
// Purpose: Behavioural configuration host on the far side of the pins
// Assumes: External clock of 400 ns, running only while a unit is sent
// Notes:   Done pin is open drain with a pull-up; hold_done_n pulls it low
`timescale 1ns/1ps
module ccp_host_model (
  // Done pin
  input  wire logic       done_o,
  input  wire logic       done_oe_n,
  input  wire logic       hold_done_n,
  output logic            done_i,
  // Config clock and data
  output logic            config_clock_i,
  output logic            cfg_din,
  output logic [7:0]      cfg_d
);
  // Pull-up only wins while neither party pulls low
  assign done_i = done_oe_n ? hold_done_n : done_o;

  initial begin
    config_clock_i = 1'b0;
    cfg_din = 1'b0;
    cfg_d = 8'h00;
  end

  ////////////////////////////////////////////////////////////
  // Data moves while the clock is low; the clock idles low between units
  task automatic send(input logic [7:0] b, input logic ser);
    #13;
    for (int i = 7; i >= (ser ? 0 : 7); i--) begin
      cfg_din = b[i];
      cfg_d = b;
      #200 config_clock_i = 1'b1;
      #200 config_clock_i = 1'b0;
    end
    // Released lines show the inverse so stale data cannot pass
    cfg_din = ~b[0];
    cfg_d = ~b;
  endtask
endmodule

// File: config_control_pins_tb.sv
// Purpose: Self-checking bench for the configuration control pins
// Assumes: AXI4-Lite master here, host model on the pins
// Notes:   Outputs are sampled at the falling edge, inputs move at the rising edge
`timescale 1ns/1ps
module config_control_pins_tb
  import ccp_pkg::*;
;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
  logic        s_bvalid, s_arready, s_rvalid, cfg_reset_pin, program_restart_n, init_pin, config_clock_i;
  logic        config_clock_o, config_clock_oe_n, cfg_din, done_i, done_o, done_oe_n, readback_cfg_n;
  logic        readback_tdo_o, host_port_irq_n, config_busy_high, config_busy_low_n, tristate_all, init_fail;
  logic        bscan_active, bscan_tdo, bscan_reset, cell_gsr, user_reset, user_io_en, hold_done_n, ser, cc, drv;
  logic [7:0]  s_awaddr, s_araddr, cfg_d, cell_state, b;
  logic [3:0]  s_wstrb, mode_sel, m, len;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic [31:0] s_wdata, s_rdata, rv;
  logic [15:0] w;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc_cnt = 0;
  integer      seed;

  ccp_top ccp_top_inst (
    .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .cfg_reset_pin, .program_restart_n, .init_pin, .mode_sel, .config_clock_i, .config_clock_o,
    .config_clock_oe_n, .cfg_din, .cfg_d, .done_i, .done_o, .done_oe_n, .readback_cfg_n, .readback_tdo_o,
    .host_port_irq_n, .config_busy_high, .config_busy_low_n, .tristate_all, .init_fail, .cell_state,
    .bscan_active, .bscan_tdo, .bscan_reset, .cell_gsr, .user_reset, .user_io_en
  );

  ccp_host_model ccp_host_model_inst (
    .done_o, .done_oe_n, .hold_done_n, .done_i, .config_clock_i, .cfg_din, .cfg_d
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Readies are registered, so the falling-edge value is what the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic [1:0] dn;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    dn = 2'h0;
    while (dn != 2'h3) begin
      @(negedge aclk);
      dn = dn | {s_awready, s_wready};
      @(posedge aclk);
      if (dn[1]) s_awvalid <= 1'b0;
      if (dn[0]) s_wvalid <= 1'b0;
    end
    s_bready <= 1'b1;
    do @(negedge aclk); while (s_bvalid !== 1'b1);
    r = s_bresp;
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(negedge aclk); while (s_arready !== 1'b1);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(negedge aclk); while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask

  task automatic restart;
    program_restart_n <= 1'b0;
    cyc(4);
    @(negedge aclk);
    chk(bscan_reset, 1'b1, "scan reset");
    chk({config_busy_high, config_busy_low_n, done_oe_n, done_o}, 4'h8, "restart outputs");
    rd(CCP_REG_STAT, rv, resp);
    chk(rv[1:0], CCP_WAIT_INIT, "restart state");
    program_restart_n <= 1'b1;
    init_pin <= 1'b0;
    cyc(4);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h0996;
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, cfg_reset_pin, init_fail} = '0;
    {bscan_active, bscan_tdo, init_pin, s_awaddr, s_araddr, s_wdata, mode_sel, cell_state} = '0;
    {program_restart_n, hold_done_n} = 2'h3;
    readback_cfg_n = 1'b1;
    s_wstrb = 4'hF;
    cyc(16);
    aresetn <= 1'b1;
    cyc(2);
    @(negedge aclk);
    chk({config_busy_high, config_busy_low_n, done_oe_n, host_port_irq_n, tristate_all}, 5'h12, "reset");
    rd(CCP_REG_LEN, rv, resp);
    chk(rv, 32'(CCP_LEN_RST), "len reset");
    rd(CCP_REG_DLY, rv, resp);
    chk(rv, 32'(CCP_DLY_RST), "delay reset");
    rd(8'h1C, rv, resp);
    chk(resp, 2'h2, "unmapped read");
    wr(8'h1C, 32'h0, resp);
    chk(resp, 2'h2, "unmapped write");
    // Clock direction per mode, with restarts from both sources
    for (int i = 0; i < 7; i++) begin
      m = (i == 5) ? 4'h4 : (i == 6) ? 4'h5 : 4'(i);
      wr(CCP_REG_CTRL, {28'h0, (i == 5), 3'h0}, resp);
      mode_sel <= m;
      init_pin <= 1'b1;
      cyc(8);
      rd(CCP_REG_STAT, rv, resp);
      chk(rv[7:0], {m, 4'h1}, "mode latch");
      @(negedge aclk);
      drv = (m < 4'h2) || (i == 5);
      chk(config_clock_oe_n, !drv, "clock direction");
      if (drv) begin
        cc = config_clock_o;
        repeat (5) @(negedge aclk);
        chk(config_clock_o, !cc, "driven clock half period");
      end
      @(posedge aclk);
      if (i == 2) begin
        cfg_reset_pin <= 1'b1;
        cyc(4);
        rd(CCP_REG_STAT, rv, resp);
        chk(rv[1:0], CCP_WAIT_INIT, "reset pin restart");
        cfg_reset_pin <= 1'b0;
      end
      if (i == 3) begin
        readback_cfg_n <= 1'b0;
        init_fail <= 1'b1;
        cyc(4);
        @(negedge aclk);
        chk(tristate_all, 1'b1, "tristate during load");
        chk(host_port_irq_n, 1'b0, "init error");
        @(posedge aclk);
        readback_cfg_n <= 1'b1;
        init_fail <= 1'b0;
      end
      restart();
    end
    // Full load, serial or byte wide, with done held low by the host
    ser = 1'($random(seed));
    len = 4'h2 + 4'($random(seed) & 3);
    wr(CCP_REG_LEN, 32'(len), resp);
    wr(CCP_REG_IRQS, 32'h0000000F, resp);
    wr(CCP_REG_IRQM, 32'h00000001, resp);
    mode_sel <= ser ? CCP_MODE_SSER : CCP_MODE_SPAR;
    init_pin <= 1'b1;
    hold_done_n <= 1'b0;
    cyc(8);
    for (int k = 0; k < len; k++) begin
      b = 8'($random(seed));
      ccp_host_model_inst.send(b, ser);
    end
    cyc(12);
    @(negedge aclk);
    chk(done_oe_n, 1'b1, "done released");
    cyc(40);
    @(negedge aclk);
    chk(config_busy_high, 1'b1, "start-up held");
    @(posedge aclk);
    hold_done_n <= 1'b1;
    cyc(12);
    @(negedge aclk);
    chk({config_busy_high, config_busy_low_n, user_io_en}, 3'h3, "start-up done");
    rd(CCP_REG_DATA, rv, resp);
    chk(rv[7:0], b, "last byte");
    @(negedge aclk);
    chk(host_port_irq_n, 1'b0, "complete irq");
    wr(CCP_REG_IRQS, 32'h00000001, resp);
    cyc(3);
    @(negedge aclk);
    chk(host_port_irq_n, 1'b1, "irq cleared");
    // Readback of four frames on the external clock
    cell_state <= 8'($random(seed));
    wr(CCP_REG_CTRL, 32'h00000001, resp);
    readback_cfg_n <= 1'b0;
    cyc(6);
    @(negedge aclk);
    chk(tristate_all, 1'b0, "trigger not tristating");
    // Each bit stands on the pin before the clock edge that moves to the next
    for (int k = 0; k < 64; k++) begin
      @(negedge aclk);
      w = {8'(k / 16), cell_state};
      chk(readback_tdo_o, w[15 - (k % 16)], "readback bit");
      ccp_host_model_inst.send(8'h00, 1'b0);
    end
    rd(CCP_REG_IRQS, rv, resp);
    chk(rv[2], 1'b1, "readback done");
    for (int v = 0; v < 2; v++) begin
      bscan_active <= 1'b1;
      bscan_tdo <= v[0];
      cyc(3);
      @(negedge aclk);
      chk(readback_tdo_o, v[0], "scan data out");
      @(posedge aclk);
    end
    bscan_active <= 1'b0;
    readback_cfg_n <= 1'b1;
    wr(CCP_REG_CTRL, 32'h00000002, resp);
    readback_cfg_n <= 1'b0;
    cyc(5);
    @(negedge aclk);
    chk(tristate_all, 1'b1, "tristate after config");
    // Reset pin once configured
    wr(CCP_REG_CTRL, 32'h00000004, resp);
    readback_cfg_n <= 1'b1;
    cfg_reset_pin <= 1'b1;
    cyc(4);
    @(negedge aclk);
    chk(cell_gsr, 1'b1, "cell set reset");
    wr(CCP_REG_CTRL, 32'h00000000, resp);
    cyc(3);
    @(negedge aclk);
    chk(user_reset, 1'b1, "plain input");
    end_of_test();
  end
endmodule
